// file: logic/see_cfg.svh
`ifndef SEE_CFG_SVH
`define SEE_CFG_SVH

// Geometry
`define SEE_WORD_W 16
`define SEE_BYTE_W 8
`define SEE_WORDS 128
`define SEE_FIFO_DEPTH 16
`define SEE_CMD_W 11
`define SEE_CMD_LEN_X16 5'h0A
`define SEE_CMD_LEN_X8 5'h0B
`define SEE_DATA_LEN_X16 5'h10
`define SEE_DATA_LEN_X8 5'h08

// Opcodes and sub-commands
`define SEE_OP_READ 2'h2
`define SEE_OP_WRITE 2'h1
`define SEE_OP_ERASE 2'h3
`define SEE_OP_EXT 2'h0
`define SEE_SUB_ENABLE 2'h3
`define SEE_SUB_DISABLE 2'h0
`define SEE_SUB_CLEAR_ALL 2'h2
`define SEE_SUB_FILL_ALL 2'h1

// Reset values
`define SEE_ERASED_WORD 16'hFFFF

// Timing
`define SEE_CLK_PERIOD_NS 10
`define SEE_PROG_TIME_NS 5000000

`endif

// file: logic/see_pkg.sv
package see_pkg;

    typedef struct packed {
        logic cs;
        logic sk;
        logic di;
        logic word_size_select;
    } see_pins_t;

    typedef enum logic [2:0] {
        SEE_IDLE = 3'b000,
        SEE_CMD = 3'b001,
        SEE_DATA = 3'b010,
        SEE_READ = 3'b011,
        SEE_WAIT = 3'b100
    } see_state_t;

    typedef enum logic [2:0] {
        SEE_PG_NONE = 3'b000,
        SEE_PG_WRITE = 3'b001,
        SEE_PG_ERASE = 3'b010,
        SEE_PG_CLEAR_ALL = 3'b011,
        SEE_PG_FILL_ALL = 3'b100
    } see_prog_t;

    typedef struct packed {
        see_prog_t kind;
        logic x8;
        logic [7:0] addr;
        logic [15:0] data;
    } see_job_t;

endpackage

// file: logic/see_port.sv
`timescale 1ns/1ps
`include "see_cfg.svh"

module see_fifo #(
    parameter int WIDTH = `SEE_WORD_W,
    parameter int DEPTH = `SEE_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic flush_in,
    // Fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] slot_reg [DEPTH];
    logic [PW:0] wr_reg;
    logic [PW:0] wr_next;
    logic [PW:0] rd_reg;
    logic [PW:0] rd_next;
    logic push;
    logic pop;

    always_comb begin
        in_ready_out = (wr_reg[PW] == rd_reg[PW]) || (wr_reg[PW-1:0] != rd_reg[PW-1:0]);
        out_valid_out = (wr_reg != rd_reg);
        out_data_out = slot_reg[rd_reg[PW-1:0]];
        push = in_valid_in && in_ready_out;
        pop = out_valid_out && out_ready_in;
        wr_next = wr_reg;
        rd_next = rd_reg;
        if (flush_in) begin
            wr_next = '0;
            rd_next = '0;
        end else begin
            if (push) begin
                wr_next = wr_reg + {{PW{1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_next = rd_reg + {{PW{1'b0}}, 1'b1};
            end
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_next;
            rd_reg <= rd_next;
        end
    end

    // Storage needs no reset: empty pointers hide stale contents
    always_ff @(posedge clk_in) begin
        if (push && !flush_in) begin
            slot_reg[wr_reg[PW-1:0]] <= in_data_in;
        end
    end
endmodule // see_fifo

module see_port #(
    parameter int PROG_CYCLES = `SEE_PROG_TIME_NS / `SEE_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Serial pins
    input wire logic chip_select_in,
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    input wire logic word_size_select_in,
    // Serial output pin
    output logic serial_data_out,
    output logic serial_data_oe_out
);
    import see_pkg::*;

    // Element index to word index; x8 packs two bytes per word
    function automatic logic [6:0] see_word_idx(input logic [7:0] e, input logic x8);
        see_word_idx = x8 ? e[7:1] : e[6:0];
    endfunction

    // Next element for sequential read, wrapping to zero
    function automatic logic [7:0] see_next_elem(input logic [7:0] e, input logic x8);
        see_next_elem = x8 ? e + 8'h01 : {1'b0, e[6:0] + 7'h01};
    endfunction

    see_pins_t pins;
    see_pins_t s1_reg;
    see_pins_t s2_reg;
    see_pins_t s3_reg;
    see_pins_t st_reg;
    see_pins_t st_next;
    see_pins_t prev_reg;

    always_comb begin
        pins = '{cs: chip_select_in, sk: serial_clock_in, di: serial_data_in,
                 word_size_select: word_size_select_in};
        // Accept a level only once two late stages agree
        st_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & st_reg);
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            st_reg <= '0;
            prev_reg <= '0;
        end else begin
            s1_reg <= pins;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            st_reg <= st_next;
            prev_reg <= st_reg;
        end
    end

    logic sk_rise;
    logic cs_fall;
    assign sk_rise = st_reg.sk && !prev_reg.sk && st_reg.cs;
    assign cs_fall = !st_reg.cs && prev_reg.cs;

    see_state_t state_reg;
    see_state_t state_next;
    logic [4:0] cnt_reg;
    logic [4:0] cnt_next;
    logic [`SEE_CMD_W-1:0] cmd_reg;
    logic [`SEE_CMD_W-1:0] cmd_next;
    logic [`SEE_WORD_W-1:0] dat_reg;
    logic [`SEE_WORD_W-1:0] dat_next;
    see_prog_t dkind_reg;
    see_prog_t dkind_next;
    see_job_t job_reg;
    see_job_t job_next;
    logic x8_reg;
    logic x8_next;
    logic enable_reg;
    logic enable_next;
    logic busy_reg;
    logic busy_next;
    logic [19:0] busy_cnt_reg;
    logic [19:0] busy_cnt_next;
    logic status_reg;
    logic status_next;
    logic dout_reg;
    logic dout_next;
    logic doe_reg;
    logic doe_next;
    logic [`SEE_WORD_W-1:0] osh_reg;
    logic [`SEE_WORD_W-1:0] osh_next;
    logic [4:0] left_reg;
    logic [4:0] left_next;
    logic [7:0] fill_reg;
    logic [7:0] fill_next;
    logic [`SEE_WORD_W-1:0] mem_reg [`SEE_WORDS];
    logic [`SEE_WORD_W-1:0] mem_next [`SEE_WORDS];

    logic fifo_flush;
    logic fifo_push;
    logic fifo_in_ready;
    logic fifo_pop;
    logic fifo_out_valid;
    logic [`SEE_WORD_W-1:0] fifo_in;
    logic [`SEE_WORD_W-1:0] fifo_out;

    see_fifo #(
        .WIDTH(`SEE_WORD_W),
        .DEPTH(`SEE_FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .flush_in(fifo_flush),
        .in_valid_in(fifo_push),
        .in_ready_out(fifo_in_ready),
        .in_data_in(fifo_in),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(fifo_pop),
        .out_data_out(fifo_out)
    );

    always_comb begin
        logic [`SEE_CMD_W-1:0] cw;
        logic [1:0] op;
        logic [1:0] sub;
        logic [7:0] elem;
        logic [`SEE_WORD_W-1:0] dw;
        logic [`SEE_WORD_W-1:0] w;
        logic [`SEE_WORD_W-1:0] rw;
        logic [6:0] wi;
        cw = {cmd_reg[`SEE_CMD_W-2:0], st_reg.di};
        op = x8_reg ? cw[10:9] : cw[9:8];
        sub = x8_reg ? cw[8:7] : cw[7:6];
        // Top address bit is a don't-care for both sizes
        elem = x8_reg ? cw[7:0] : {1'b0, cw[6:0]};
        dw = {dat_reg[`SEE_WORD_W-2:0], st_reg.di};
        w = '0;
        rw = '0;
        wi = '0;
        state_next = state_reg;
        cnt_next = cnt_reg;
        cmd_next = cmd_reg;
        dat_next = dat_reg;
        dkind_next = dkind_reg;
        job_next = job_reg;
        x8_next = x8_reg;
        enable_next = enable_reg;
        busy_next = busy_reg;
        busy_cnt_next = busy_cnt_reg;
        status_next = status_reg;
        dout_next = dout_reg;
        doe_next = doe_reg;
        osh_next = osh_reg;
        left_next = left_reg;
        fill_next = fill_reg;
        mem_next = mem_reg;
        fifo_flush = 1'b0;
        fifo_pop = 1'b0;

        // Self-timed cycle runs on the system clock alone
        if (busy_reg) begin
            if (busy_cnt_reg == 20'h00000) begin
                busy_next = 1'b0;
                wi = see_word_idx(job_reg.addr, job_reg.x8);
                rw = mem_reg[wi];
                // Byte 0 of a word is its upper half in x8 mode
                if (job_reg.x8) begin
                    if (job_reg.addr[0]) begin
                        rw[7:0] = (job_reg.kind == SEE_PG_WRITE) ? job_reg.data[7:0] : 8'hFF;
                    end else begin
                        rw[15:8] = (job_reg.kind == SEE_PG_WRITE) ? job_reg.data[7:0] : 8'hFF;
                    end
                end else begin
                    rw = (job_reg.kind == SEE_PG_WRITE) ? job_reg.data : `SEE_ERASED_WORD;
                end
                case (job_reg.kind)
                    SEE_PG_WRITE, SEE_PG_ERASE: begin
                        mem_next[wi] = rw;
                    end
                    SEE_PG_CLEAR_ALL: begin
                        for (int i = 0; i < `SEE_WORDS; i++) begin
                            mem_next[i] = `SEE_ERASED_WORD;
                        end
                    end
                    SEE_PG_FILL_ALL: begin
                        for (int i = 0; i < `SEE_WORDS; i++) begin
                            mem_next[i] = job_reg.x8 ? {2{job_reg.data[7:0]}} : job_reg.data;
                        end
                    end
                    default: begin
                    end
                endcase
                job_next.kind = SEE_PG_NONE;
            end else begin
                busy_cnt_next = busy_cnt_reg - 20'h00001;
            end
        end

        if (cs_fall) begin
            state_next = SEE_IDLE;
            doe_next = 1'b0;
            fifo_flush = 1'b1;
            if (job_reg.kind != SEE_PG_NONE && !busy_reg) begin
                busy_next = 1'b1;
                busy_cnt_next = 20'(PROG_CYCLES - 1);
                status_next = 1'b1;
            end
        end else begin
            if (status_reg && st_reg.cs) begin
                doe_next = 1'b1;
                dout_next = !busy_reg;
            end
            if (sk_rise) begin
                if (status_reg && st_reg.di) begin
                    doe_next = 1'b0;
                    status_next = 1'b0;
                end
                case (state_reg)
                    SEE_IDLE: begin
                        // New instructions wait until the program cycle ends
                        if (st_reg.di && !busy_reg) begin
                            state_next = SEE_CMD;
                            cnt_next = 5'h00;
                            cmd_next = '0;
                            x8_next = !st_reg.word_size_select;
                        end
                    end
                    SEE_CMD: begin
                        cmd_next = cw;
                        cnt_next = cnt_reg + 5'h01;
                        if (cnt_reg == (x8_reg ? `SEE_CMD_LEN_X8 : `SEE_CMD_LEN_X16) - 5'h01) begin
                            state_next = SEE_WAIT;
                            cnt_next = 5'h00;
                            job_next.addr = elem;
                            job_next.x8 = x8_reg;
                            case (op)
                                `SEE_OP_READ: begin
                                    state_next = SEE_READ;
                                    doe_next = 1'b1;
                                    dout_next = 1'b0;
                                    left_next = 5'h00;
                                    fill_next = elem;
                                    fifo_flush = 1'b1;
                                end
                                `SEE_OP_WRITE: begin
                                    state_next = SEE_DATA;
                                    dkind_next = SEE_PG_WRITE;
                                end
                                `SEE_OP_ERASE: begin
                                    if (enable_reg) begin
                                        job_next.kind = SEE_PG_ERASE;
                                    end
                                end
                                default: begin
                                    case (sub)
                                        `SEE_SUB_ENABLE: begin
                                            enable_next = 1'b1;
                                        end
                                        `SEE_SUB_DISABLE: begin
                                            enable_next = 1'b0;
                                        end
                                        `SEE_SUB_CLEAR_ALL: begin
                                            if (enable_reg) begin
                                                job_next.kind = SEE_PG_CLEAR_ALL;
                                            end
                                        end
                                        default: begin
                                            state_next = SEE_DATA;
                                            dkind_next = SEE_PG_FILL_ALL;
                                        end
                                    endcase
                                end
                            endcase
                        end
                    end
                    SEE_DATA: begin
                        dat_next = dw;
                        cnt_next = cnt_reg + 5'h01;
                        if (cnt_reg == (x8_reg ? `SEE_DATA_LEN_X8 : `SEE_DATA_LEN_X16) - 5'h01) begin
                            state_next = SEE_WAIT;
                            if (enable_reg) begin
                                job_next.kind = dkind_reg;
                                job_next.data = dw;
                            end
                        end
                    end
                    SEE_READ: begin
                        // Output bit changes on each clock rise
                        if (left_reg == 5'h00) begin
                            fifo_pop = fifo_out_valid;
                            w = x8_reg ? {fifo_out[7:0], 8'h00} : fifo_out;
                            dout_next = w[15];
                            osh_next = {w[14:0], 1'b0};
                            left_next = (x8_reg ? `SEE_DATA_LEN_X8 : `SEE_DATA_LEN_X16) - 5'h01;
                        end else begin
                            dout_next = osh_reg[15];
                            osh_next = {osh_reg[14:0], 1'b0};
                            left_next = left_reg - 5'h01;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // Prefetch keeps the read path ahead of the serial clock
        fifo_push = (state_reg == SEE_READ) && !fifo_flush;
        rw = mem_reg[see_word_idx(fill_reg, x8_reg)];
        fifo_in = x8_reg ? {8'h00, (fill_reg[0] ? rw[7:0] : rw[15:8])} : rw;
        if (fifo_push && fifo_in_ready) begin
            fill_next = see_next_elem(fill_reg, x8_reg);
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_reg <= SEE_IDLE;
            cnt_reg <= 5'h00;
            cmd_reg <= '0;
            dat_reg <= '0;
            dkind_reg <= SEE_PG_NONE;
            job_reg <= '0;
            x8_reg <= 1'b0;
            enable_reg <= 1'b0;
            busy_reg <= 1'b0;
            busy_cnt_reg <= 20'h00000;
            status_reg <= 1'b0;
            dout_reg <= 1'b0;
            doe_reg <= 1'b0;
            osh_reg <= '0;
            left_reg <= 5'h00;
            fill_reg <= 8'h00;
            for (int i = 0; i < `SEE_WORDS; i++) begin
                mem_reg[i] <= `SEE_ERASED_WORD;
            end
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            cmd_reg <= cmd_next;
            dat_reg <= dat_next;
            dkind_reg <= dkind_next;
            job_reg <= job_next;
            x8_reg <= x8_next;
            enable_reg <= enable_next;
            busy_reg <= busy_next;
            busy_cnt_reg <= busy_cnt_next;
            status_reg <= status_next;
            dout_reg <= dout_next;
            doe_reg <= doe_next;
            osh_reg <= osh_next;
            left_reg <= left_next;
            fill_reg <= fill_next;
            mem_reg <= mem_next;
        end
    end

    assign serial_data_out = dout_reg;
    assign serial_data_oe_out = doe_reg;
endmodule // see_port

// file: verification/see_host.sv
`timescale 1ns/1ps

module see_host (
    // Clock
    input wire logic clk_in,
    // Device pins
    output logic cs_out,
    output logic sk_out,
    output logic di_out,
    input wire logic do_in,
    input wire logic oe_in,
    // Results
    output logic [15:0] rx_word_out,
    output logic rx_stb_out
);
    logic last_reg = 1'b0;
    logic do_line;

    // A released line shows the inverse of its last level, never a lucky match
    always @(posedge clk_in) begin
        if (oe_in) begin
            last_reg <= do_in;
        end
    end
    assign do_line = oe_in ? do_in : ~last_reg;

    initial begin
        cs_out = 1'b0;
        sk_out = 1'b0;
        di_out = 1'b0;
        rx_word_out = 16'h0;
        rx_stb_out = 1'b0;
    end

    task automatic put(input logic [15:0] w);
        rx_word_out <= w;
        rx_stb_out <= 1'b1;
        @(posedge clk_in);
        rx_stb_out <= 1'b0;
    endtask

    // DI held 4 clk before and 12 after each rise; sample late in the low phase
    task automatic tick(input logic b, output logic [1:0] s);
        di_out <= b;
        repeat (4) @(posedge clk_in);
        sk_out <= 1'b1;
        repeat (8) @(posedge clk_in);
        sk_out <= 1'b0;
        repeat (4) @(posedge clk_in);
        s = {oe_in, do_line};
    endtask

    task automatic frame_on();
        cs_out <= 1'b1;
        repeat (8) @(posedge clk_in);
    endtask

    task automatic frame_off();
        di_out <= 1'b0;
        cs_out <= 1'b0;
        repeat (8) @(posedge clk_in);
    endtask

    task automatic send(input logic [27:0] v, input int n, output logic [1:0] s);
        for (int i = n - 1; i >= 0; i--) begin
            tick(v[i], s);
        end
    endtask

    task automatic cmd(input logic [27:0] v, input int n);
        logic [1:0] s;
        frame_on();
        send(v, n, s);
        frame_off();
    endtask

    task automatic read(input logic [27:0] v, input int n, input int words, input int w);
        logic [1:0] s;
        logic [15:0] acc;
        frame_on();
        send(v, n, s);
        put({14'h0, s});
        for (int j = 0; j < words; j++) begin
            acc = 16'h0;
            for (int i = 0; i < w; i++) begin
                tick(1'b0, s);
                acc = {acc[14:0], s[0]};
            end
            put(acc);
        end
        frame_off();
    endtask

    // Result bits: enabled, busy-low, ready seen, still enabled after dummy one
    task automatic poll();
        logic [3:0] r;
        logic [1:0] s;
        frame_on();
        r = {oe_in, oe_in & do_line, 2'b00};
        for (int k = 0; k < 400 && !r[1]; k++) begin
            @(posedge clk_in);
            r[1] = oe_in & do_line;
        end
        tick(1'b1, s);
        r[0] = s[1];
        put({12'h0, r});
        frame_off();
    endtask
endmodule // see_host

// file: verification/see_port_properties.sv
`timescale 1ns/1ps

module see_port_checker #(
    parameter int PROG_CYCLES = 500000
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // Serial pins
    input wire logic chip_select_in,
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    input wire logic word_size_select_in,
    input wire logic serial_data_out,
    input wire logic serial_data_oe_out
);
    logic sk_reg;
    logic sk_rise;
    logic [7:0] rise_cnt_reg;
    logic [7:0] cs_low_cnt_reg;
    logic [19:0] busy_cnt_reg;

    assign sk_rise = serial_clock_in && !sk_reg;

    // Saturating ages since the last clock rise and the last deselect
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sk_reg <= 1'b0;
            rise_cnt_reg <= 8'hFF;
            cs_low_cnt_reg <= 8'hFF;
            busy_cnt_reg <= 20'h0;
        end else begin
            sk_reg <= serial_clock_in;
            rise_cnt_reg <= sk_rise ? 8'h0 : rise_cnt_reg + {7'h0, rise_cnt_reg != 8'hFF};
            cs_low_cnt_reg <= !chip_select_in ? 8'h0 :
                cs_low_cnt_reg + {7'h0, cs_low_cnt_reg != 8'hFF};
            busy_cnt_reg <= (serial_data_oe_out && !serial_data_out && !sk_rise) ?
                busy_cnt_reg + 20'h1 : 20'h0;
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    a_reset_quiet: assert property ($rose(reset_n_in) |-> !serial_data_oe_out)
        else $error("output enabled right after reset");
    a_deselect_release: assert property (!chip_select_in [*6] |-> !serial_data_oe_out)
        else $error("output still enabled while deselected");
    a_drive_selected: assert property ($rose(serial_data_oe_out) |-> $past(chip_select_in, 3))
        else $error("output enabled without chip select");
    a_read_on_rise: assert property (serial_data_oe_out && $past(serial_data_oe_out)
        && $fell(serial_data_out) |-> rise_cnt_reg <= 8'd7)
        else $error("read bit changed away from a clock rise");
    a_busy_bounded: assert property (busy_cnt_reg <= PROG_CYCLES + 16)
        else $error("busy status held too long");
    a_dummy_zero: assert property ($rose(serial_data_oe_out) && rise_cnt_reg <= 8'd7
        |-> !serial_data_out)
        else $error("read did not open with a zero bit");
    a_release_cause: assert property ($fell(serial_data_oe_out)
        |-> rise_cnt_reg <= 8'd7 || cs_low_cnt_reg <= 8'd7)
        else $error("output released without clock rise or deselect");
    a_status_rises: assert property (serial_data_oe_out && $past(serial_data_oe_out)
        && rise_cnt_reg > 8'd10 && $changed(serial_data_out) |-> serial_data_out)
        else $error("status went from ready back to busy");

    c_read_start: cover property ($rose(serial_data_oe_out) && !serial_data_out);
    c_status_ready: cover property (serial_data_oe_out && $rose(serial_data_out));
    c_dummy_release: cover property ($fell(serial_data_oe_out) && chip_select_in);
    c_dummy_one: cover property (serial_data_in && sk_rise && serial_data_oe_out);
    c_byte_read: cover property (!word_size_select_in && $rose(serial_data_oe_out));
endmodule // see_port_checker

bind see_port see_port_checker #(.PROG_CYCLES(PROG_CYCLES)) chk_u (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .chip_select_in(chip_select_in),
    .serial_clock_in(serial_clock_in),
    .serial_data_in(serial_data_in),
    .word_size_select_in(word_size_select_in),
    .serial_data_out(serial_data_out),
    .serial_data_oe_out(serial_data_oe_out)
);

// file: verification/see_port_test.sv
`timescale 1ns/1ps
`include "see_cfg.svh"

module see_port_test;
    import see_pkg::*;

    localparam int PROG = 50;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic word_size_select_in = 1'b1;
    logic cs, sk, di, dout, doe, rx_stb;
    logic [15:0] rx_word;
    logic [15:0] d;
    logic [15:0] exp_q[$];
    integer seed = 32'h5b5d;
    int num_errors = 0;
    int num_checks = 0;

    always #5 clk_in = ~clk_in;

    see_port #(.PROG_CYCLES(PROG)) dut_u (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .chip_select_in(cs),
        .serial_clock_in(sk),
        .serial_data_in(di),
        .word_size_select_in(word_size_select_in),
        .serial_data_out(dout),
        .serial_data_oe_out(doe)
    );

    see_host host_u (
        .clk_in(clk_in),
        .cs_out(cs),
        .sk_out(sk),
        .di_out(di),
        .do_in(dout),
        .oe_in(doe),
        .rx_word_out(rx_word),
        .rx_stb_out(rx_stb)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("BAD %0t: got %h want %h", $time, seen, want);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        if (rx_stb === 1'b1) begin
            if (exp_q.size() > 0) begin
                check(rx_word, exp_q.pop_front());
            end else begin
                num_errors++;
                $display("BAD %0t: result with no expectation", $time);
            end
        end
    end

    function automatic logic [27:0] w16(logic [1:0] c, logic [7:0] a);
        return {17'h0, 1'b1, c, a};
    endfunction

    function automatic logic [27:0] w8(logic [1:0] c, logic [8:0] a);
        return {16'h0, 1'b1, c, a};
    endfunction

    task automatic op(input logic [27:0] v, input int n, input logic [3:0] st);
        host_u.cmd(v, n);
        exp_q.push_back({12'h0, st});
        host_u.poll();
    endtask

    // Every read takes two words, so the second shows the advance
    task automatic rd(input logic [27:0] v, input int n, input int w, input logic [15:0] a,
                      input logic [15:0] b);
        exp_q.push_back(16'h0002);
        exp_q.push_back(a);
        exp_q.push_back(b);
        host_u.read(v, n, 2, w);
    endtask

    initial begin
        repeat (10) @(posedge clk_in);
        reset_n_in <= 1'b1;
        // Settle time after reset, scaled down to keep the run short
        repeat (20) @(posedge clk_in);
        d = 16'($random(seed));
        op((w16(`SEE_OP_WRITE, 8'h03) << 16) | d, 27, 4'h0);
        rd(w16(`SEE_OP_READ, 8'h03), 11, 16, 16'hFFFF, 16'hFFFF);
        host_u.cmd(w16(`SEE_OP_EXT, {`SEE_SUB_ENABLE, 6'h0}) >> 1, 10);
        op(w16(`SEE_OP_ERASE, 8'h03), 11, 4'h0);
        // A swallowed partial enable would make this erase start a cycle
        op(w16(`SEE_OP_ERASE, 8'h03), 11, 4'h0);
        op(w16(`SEE_OP_EXT, {`SEE_SUB_ENABLE, 6'h0}), 11, 4'h0);
        op((w16(`SEE_OP_WRITE, {d[0], 7'h7F}) << 16) | d, 27, 4'hA);
        rd(w16(`SEE_OP_READ, 8'h7F), 11, 16, d, 16'hFFFF);
        op(w16(`SEE_OP_ERASE, 8'h7F), 11, 4'hA);
        rd(w16(`SEE_OP_READ, 8'h7F), 11, 16, 16'hFFFF, 16'hFFFF);
        d = 16'($random(seed));
        op((w16(`SEE_OP_EXT, {`SEE_SUB_FILL_ALL, 6'h0}) << 16) | d, 27, 4'hA);
        rd(w16(`SEE_OP_READ, 8'h7F), 11, 16, d, d);
        op(w16(`SEE_OP_EXT, {`SEE_SUB_CLEAR_ALL, 6'h0}), 11, 4'hA);
        rd(w16(`SEE_OP_READ, 8'h05), 11, 16, 16'hFFFF, 16'hFFFF);
        word_size_select_in <= 1'b0;
        d = 16'($random(seed));
        op((w8(`SEE_OP_WRITE, 9'h00B) << 8) | {20'h0, d[7:0]}, 20, 4'hA);
        rd(w8(`SEE_OP_READ, 9'h00A), 12, 8, 16'h00FF, {8'h0, d[7:0]});
        op(w8(`SEE_OP_EXT, {`SEE_SUB_DISABLE, 7'h0}), 12, 4'h0);
        op(w8(`SEE_OP_ERASE, 9'h00B), 12, 4'h0);
        rd(w8(`SEE_OP_READ, 9'h00B), 12, 8, {8'h0, d[7:0]}, 16'h00FF);
        repeat (10) @(posedge clk_in);
        check(16'(exp_q.size()), 16'h0000);
        final_report();
    end

    // The sequence needs well under a millisecond
    initial begin
        #1000000;
        num_errors++;
        final_report();
    end
endmodule // see_port_test
